// ==== verification/ext_mem_model.sv ====
// Purpose: External memory on the far side of the decoder
// Assumes: One request at a time, held until done
// Notes:   Read data is scrambled whenever no answer is given
`timescale 1ns/1ps
module ext_mem_model (
    // Clock and reset
    input  wire        clk,
    input  wire        rst,
    // Request from the decoder
    input  wire        ext_req,
    input  wire        ext_write,
    input  wire [23:0] ext_addr,
    input  wire [15:0] ext_wdata,
    input  wire [3:0]  wait_cycles,
    // Answer and observation
    output reg         ext_done,
    output reg  [15:0] ext_rdata,
    output reg  [23:0] last_addr_ff,
    output reg  [7:0]  req_count_ff
);
    reg [15:0] mem [0:255];
    reg [3:0]  cnt_ff;
    reg        seen_ff;
    // ----------------------------------------
    // Answer after wait_cycles, done for one cycle
    // ----------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_done <= 1'b0;
            ext_rdata <= 16'h0000;
            cnt_ff <= 4'h0;
            seen_ff <= 1'b0;
            last_addr_ff <= 24'h000000;
            req_count_ff <= 8'h00;
        end else begin
            ext_done <= 1'b0;
            ext_rdata <= ~ext_rdata;
            seen_ff <= ext_req;
            if (ext_req && !seen_ff) begin
                req_count_ff <= req_count_ff + 8'h01;
                last_addr_ff <= ext_addr;
            end
            if (ext_req && !ext_done) begin
                if (cnt_ff == wait_cycles) begin
                    cnt_ff <= 4'h0;
                    ext_done <= 1'b1;
                    ext_rdata <= mem[ext_addr[8:1]];
                    if (ext_write)
                        mem[ext_addr[8:1]] <= ext_wdata;
                end else
                    cnt_ff <= cnt_ff + 4'h1;
            end
        end
    end
endmodule

// ==== verification/mem_area_decode_test.sv ====
// Purpose: Self-checking bench for the memory area decoder
// Assumes: Requests driven at the rising edge, one outstanding
// Notes:   ROM image is address xor a fixed pattern
`timescale 1ns/1ps
module mem_area_decode_test;
    reg         REF_CLK, RESET, EXTENSION_RAM_ENABLE_BIT, ROM_ENABLE, EXTERNAL_ACCESS_PIN_N, REQ;
    reg         REQ_WRITE, REQ_BYTE, REQ_FETCH, REQ_SHORT, REQ_BIT, REQ_STACK, REQ_PEC;
    reg         REQ_LONG, SEG_BRANCH;
    reg  [39:0] DATA_PAGE_POINTER;
    reg  [1:0]  STRAP_BUS_MODE, STRAP_SEG_MODE;
    reg  [7:0]  REQ_SEG, SEG_TARGET;
    reg  [15:0] REQ_ADDR, REQ_WDATA, rd;
    reg  [3:0]  wait_cycles;
    reg         flt;
    wire        DONE, FAULT, ROM_RD, EXT_REQ, EXT_WRITE, START_EXTERNAL, EXT_DONE;
    wire [15:0] RDATA, EXT_RDATA, EXT_WDATA;
    wire [7:0]  CODE_SEGMENT_POINTER, req_count;
    wire [23:0] ROM_ADDR, EXT_ADDR, last_addr;
    wire [1:0]  BUS_MODE;
    wire [5:0]  SEG_LINES_MASK;
    wire [15:0] ROM_RDATA = ROM_ADDR[15:0] ^ 16'h5A5A;
    integer     failures, cmp_count, cycles, i;

    mem_area_decode DUT (.*);
    ext_mem_model far_mem (.clk(REF_CLK), .rst(RESET), .ext_req(EXT_REQ),
        .ext_write(EXT_WRITE), .ext_addr(EXT_ADDR), .ext_wdata(EXT_WDATA),
        .wait_cycles(wait_cycles), .ext_done(EXT_DONE), .ext_rdata(EXT_RDATA),
        .last_addr_ff(last_addr), .req_count_ff(req_count));

    // ----------------------------------------
    // Clock and hang guard
    // ----------------------------------------
    initial begin
        REF_CLK = 1'b0;
        forever #25 REF_CLK = ~REF_CLK;
    end
    always @(posedge REF_CLK) begin
        cycles = cycles + 1;
        if (cycles == 6000) begin
            failures = failures + 1;
            report_and_stop;
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task check(input [8*10-1:0] what, input [23:0] exp, input [23:0] got);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("unexpected %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task acc(input [15:0] a, input w, input [15:0] wd, input [3:0] fl);
        integer n;
        begin
            @(posedge REF_CLK);
            REQ <= 1'b1;
            REQ_ADDR <= a;
            REQ_WRITE <= w;
            REQ_WDATA <= wd;
            {REQ_PEC, REQ_STACK, REQ_BIT, REQ_SHORT} <= fl;
            n = 0;
            @(posedge REF_CLK);
            while (DONE !== 1'b1 && n < 40) begin
                @(posedge REF_CLK);
                n = n + 1;
            end
            check("done", 24'h1, {23'h0, DONE});
            rd = RDATA;
            flt = FAULT;
            REQ <= 1'b0;
            {REQ_PEC, REQ_STACK, REQ_BIT, REQ_SHORT} <= 4'h0;
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", cmp_count, failures);
            if (failures == 0 && cmp_count > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {EXTENSION_RAM_ENABLE_BIT, ROM_ENABLE, REQ, REQ_WRITE, REQ_BYTE, REQ_FETCH} <= 6'h00;
        {REQ_SHORT, REQ_BIT, REQ_STACK, REQ_PEC, REQ_LONG, SEG_BRANCH} <= 6'h00;
        {REQ_SEG, SEG_TARGET, REQ_ADDR, REQ_WDATA} <= 48'h0;
        DATA_PAGE_POINTER <= {10'h003, 10'h000, 10'h000, 10'h040};
        wait_cycles <= 4'h0;
        failures = 0;
        cmp_count = 0;
        cycles = 0;
        // Every bus mode, segment width and start area caught from the straps
        for (i = 0; i < 4; i = i + 1) begin
            RESET                 <= 1'b1;
            STRAP_BUS_MODE        <= i[1:0];
            STRAP_SEG_MODE        <= i[1:0];
            EXTERNAL_ACCESS_PIN_N <= i[0];
            repeat (2) @(posedge REF_CLK);
            check("reset bus", 24'h0, {22'h0, BUS_MODE});
            RESET <= 1'b0;
            repeat (3) @(posedge REF_CLK);
            check("bus mode", i, {22'h0, BUS_MODE});
            check("seg mask", (1 << (2 * i)) - 1, {18'h0, SEG_LINES_MASK});
            check("start ext", {23'h0, ~i[0]}, {23'h0, START_EXTERNAL});
        end
        $display("test straps done");
        // Disabled window falls through to external memory
        acc(16'hE000, 1'b1, 16'h1234, 4'h0);
        acc(16'hE000, 1'b0, 16'h0000, 4'h0);
        check("ext data", 24'h1234, {8'h0, rd});
        check("ext addr", 24'h00E000, last_addr);
        acc(16'h2000, 1'b0, 16'h0000, 4'h0);
        check("page addr", 24'h102000, last_addr);
        acc(16'h2000, 1'b0, 16'h0000, 4'h8);
        check("pec addr", 24'h002000, last_addr);
        acc(16'h4010, 1'b0, 16'h0000, 4'h0);
        check("free addr", 24'h000010, last_addr);
        REQ_LONG <= 1'b1;
        REQ_SEG  <= 8'h05;
        acc(16'h3456, 1'b0, 16'h0000, 4'h0);
        REQ_LONG <= 1'b0;
        check("long addr", 24'h053456, last_addr);
        $display("test external done");
        // Enabled window served inside, edges of the window, byte lane, fetch
        EXTENSION_RAM_ENABLE_BIT <= 1'b1;
        i = req_count;
        acc(16'hE7FE, 1'b1, 16'hBEEF, 4'h0);
        acc(16'hE000, 1'b1, 16'hCAFE, 4'h0);
        acc(16'hE7FE, 1'b0, 16'h0000, 4'h0);
        check("top word", 24'h00BEEF, {8'h0, rd});
        acc(16'hE000, 1'b0, 16'h0000, 4'h0);
        check("low word", 24'h00CAFE, {8'h0, rd});
        REQ_BYTE <= 1'b1;
        acc(16'hE001, 1'b1, 16'h7700, 4'h0);
        REQ_BYTE <= 1'b0;
        acc(16'hE000, 1'b0, 16'h0000, 4'h0);
        check("byte lane", 24'h0077FE, {8'h0, rd});
        REQ_FETCH <= 1'b1;
        acc(16'hE7FE, 1'b0, 16'h0000, 4'h0);
        REQ_FETCH <= 1'b0;
        check("extension_ram fetch", 24'h00BEEF, {8'h0, rd});
        check("ext count", i, {16'h0, req_count});
        wait_cycles <= 4'h6;
        acc(16'hE800, 1'b0, 16'h0000, 4'h0);
        check("above win", 24'h00E800, last_addr);
        $display("test window done");
        // Short, bit, stack and odd word access refused
        for (i = 0; i < 3; i = i + 1) begin
            acc(16'hE000, 1'b0, 16'h0000, 4'h1 << i);
            check("refusal", 24'h1, {23'h0, flt});
        end
        acc(16'hE001, 1'b0, 16'h0000, 4'h0);
        check("odd word", 24'h1, {23'h0, flt});
        acc(16'h2000, 1'b0, 16'h0000, 4'h1);
        check("ext short", 24'h1, {23'h0, flt});
        $display("test refusals done");
        // Unprotected ROM gives true contents
        ROM_ENABLE <= 1'b1;
        acc(16'h4010, 1'b0, 16'h0000, 4'h0);
        check("rom data", 24'h005A4A, {8'h0, rd});
        $display("test rom done");
        // Code segment takes the branch target and holds through a later request
        @(posedge REF_CLK);
        SEG_BRANCH <= 1'b1;
        SEG_TARGET <= 8'h2A;
        @(posedge REF_CLK);
        SEG_BRANCH <= 1'b0;
        acc(16'h4010, 1'b0, 16'h0000, 4'h0);
        check("code seg", 24'h00002A, {16'h0, CODE_SEGMENT_POINTER});
        $display("test segment done");
        report_and_stop;
    end
endmodule

// ==== verification/mem_area_monitor.sv ====
// Purpose: Port checks for the memory area decoder
// Assumes: Enables, pointers and straps steady around each request
// Notes:   Bound to every mem_area_decode instance
`timescale 1ns/1ps
module mem_area_monitor (
    // Clock and reset
    input wire        REF_CLK,
    input wire        RESET,
    // Configuration and request
    input wire        EXTENSION_RAM_ENABLE_BIT,
    input wire        ROM_ENABLE,
    input wire [39:0] DATA_PAGE_POINTER,
    input wire        REQ,
    input wire        REQ_SHORT,
    input wire        REQ_BIT,
    input wire        REQ_STACK,
    input wire        REQ_PEC,
    input wire        REQ_FETCH,
    input wire        REQ_LONG,
    input wire [15:0] REQ_ADDR,
    input wire        SEG_BRANCH,
    input wire [7:0]  SEG_TARGET,
    input wire        EXT_DONE,
    // Answers
    input wire        DONE,
    input wire        FAULT,
    input wire [7:0]  CODE_SEGMENT_POINTER,
    input wire        ROM_RD,
    input wire        EXT_REQ,
    input wire [23:0] EXT_ADDR
);
    // ----------------------------------------
    // Request classes
    // ----------------------------------------
    wire plain = !(REQ_SHORT | REQ_BIT | REQ_STACK | REQ_PEC | REQ_FETCH | REQ_LONG)
                 && !REQ_ADDR[0];
    wire xwin  = DATA_PAGE_POINTER[39:30] == 10'h003 && REQ_ADDR[15:11] == 5'h1C;
    wire rwin  = ROM_ENABLE && DATA_PAGE_POINTER[19:10] == 10'h000 && REQ_ADDR[15:14] == 2'h1;

    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RESET);

    fault_with_done_a: assert property (FAULT |-> DONE)
        else $error("fault raised without done");
    done_pulse_a: assert property (DONE |=> !DONE)
        else $error("done held past one cycle");
    extension_ram_internal_a: assert property ($rose(REQ) && xwin && plain && EXTENSION_RAM_ENABLE_BIT
        |-> !EXT_REQ[*3] ##1 (DONE && !FAULT)) else $error("extension ram cycle wrong");
    extension_ram_off_a: assert property ($rose(REQ) && xwin && plain && !EXTENSION_RAM_ENABLE_BIT
        |=> EXT_REQ && EXT_ADDR == {8'h00, REQ_ADDR}) else $error("disabled window not external");
    short_refused_a: assert property ($rose(REQ) && REQ_SHORT && xwin |=> DONE && FAULT)
        else $error("short access not refused");
    ext_answer_a: assert property (EXT_REQ && EXT_DONE |=> DONE && !EXT_REQ)
        else $error("external answer not passed on");
    no_ext_window_a: assert property (EXT_REQ && EXTENSION_RAM_ENABLE_BIT |-> EXT_ADDR[23:11] != 13'h001C)
        else $error("enabled window reached external bus");
    rom_path_a: assert property ($rose(REQ) && rwin && plain |=> ROM_RD ##1 DONE)
        else $error("rom read timing wrong");
    seg_hold_a: assert property (CODE_SEGMENT_POINTER ==
        ($past(SEG_BRANCH) ? $past(SEG_TARGET) : $past(CODE_SEGMENT_POINTER)))
        else $error("code segment changed without branch");
endmodule

bind mem_area_decode mem_area_monitor u_mon (.*);

// ==== verilog/mem_area_decode.v ====
// Purpose: Memory area decode, extension RAM, external bus fallback
// Assumes: CPU presents one request at a time and waits for DONE
// Notes:   Bus mode and memory model are caught on reset release
//
// How it works
// - 2 KB extension RAM, 1K x 16, inside data page 3
// - Extension RAM enable resets to zero
// - Disabled extension RAM window goes to external bus
// - Enabled extension RAM served internally, no external cycle
// - Window is 00'E000 to 00'E7FF inclusive
// - Extension RAM cycle: 16-bit demultiplexed, 4 clock phases, no waits
// - Window select is hardwired and not software visible
// - Word accesses on even addresses; last word 00'E7FE
// - No bit addressing, stack or register banks in extension RAM
// - 16 MB space; unclaimed addresses go external
// - Segment lines: none, 2, 4 or 6 bits
// - Mux/demux, 16/8-bit buses; mux 16-bit default
// - Memory model and bus mode captured at the first clock edge after reset release
// - Only indirect or long addressing reaches these areas
// - Transfer-engine pointers reach segment 0 directly
// - Code segment changes only on segment jump, call, return
// - Top address bits choose one of four page pointers
// - ROM protection fixed at build
// - Protected ROM data read from outside returns 009B
// - Protected ROM fetch from outside returns 009B trap
`timescale 1ns/1ps
`include "mem_decode_map.vh"
module mem_area_decode #(
    parameter ROM_PROTECT = 1'b0
) (
    // Clock and reset
    input  wire        REF_CLK,
    input  wire        RESET,
    // Configuration
    input  wire        EXTENSION_RAM_ENABLE_BIT,
    input  wire        ROM_ENABLE,
    input  wire [39:0] DATA_PAGE_POINTER,
    // Reset straps
    input  wire        EXTERNAL_ACCESS_PIN_N,
    input  wire [1:0]  STRAP_BUS_MODE,
    input  wire [1:0]  STRAP_SEG_MODE,
    // CPU request
    input  wire        REQ,
    input  wire        REQ_WRITE,
    input  wire        REQ_BYTE,
    input  wire        REQ_FETCH,
    input  wire        REQ_SHORT,
    input  wire        REQ_BIT,
    input  wire        REQ_STACK,
    input  wire        REQ_PEC,
    input  wire        REQ_LONG,
    input  wire [7:0]  REQ_SEG,
    input  wire [15:0] REQ_ADDR,
    input  wire [15:0] REQ_WDATA,
    // Segment branch
    input  wire        SEG_BRANCH,
    input  wire [7:0]  SEG_TARGET,
    // Internal ROM data
    input  wire [15:0] ROM_RDATA,
    // External bus answer
    input  wire        EXT_DONE,
    input  wire [15:0] EXT_RDATA,
    // CPU answer
    output reg         DONE,
    output reg         FAULT,
    output reg  [15:0] RDATA,
    output reg  [7:0]  CODE_SEGMENT_POINTER,
    // ROM port
    output reg         ROM_RD,
    output reg  [23:0] ROM_ADDR,
    // External bus request
    output reg         EXT_REQ,
    output reg         EXT_WRITE,
    output reg  [23:0] EXT_ADDR,
    output reg  [15:0] EXT_WDATA,
    output reg  [1:0]  BUS_MODE,
    output reg  [5:0]  SEG_LINES_MASK,
    output reg         START_EXTERNAL
);
    // ------------------------------------------------------------
    // States and area codes
    // ------------------------------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_EXTENSION_RAM = 2'h1;
    localparam ST_EXT  = 2'h2;
    localparam ST_ROM  = 2'h3;

    // Last operating clock of the extension RAM cycle
    localparam [2:0] EXTENSION_RAM_END_PH = `EXTENSION_RAM_CYCLE_CLK - 3'h1;

    reg [1:0]  state_ff;
    reg [2:0]  phase_ff;
    reg        strap_done_ff;
    reg [15:0] extension_ram_ff [0:`EXTENSION_RAM_WORDS-1];
    reg [9:0]  widx_ff;
    reg        wbyte_ff;
    reg        wsel_ff;
    reg        wen_ff;
    reg [15:0] wdata_ff;
    reg        fetch_ff;
    reg        rom_hit_ff;
    reg        extension_ram_on_ff;

    wire [23:0] code_addr;
    wire [23:0] data_addr;
    wire [23:0] phys;
    wire        in_extension_ram;
    wire        in_iram;
    wire        in_rom;
    wire        bad_mode;
    wire [15:0] guarded;
    wire        running_rom;

    // Address translation for data; code uses the segment pointer
    page_translate u_pt (
        .addr16      (REQ_ADDR),
        .direct_seg0 (REQ_PEC),
        .long_en     (REQ_LONG),
        .long_seg    (REQ_SEG),
        .page_ptrs   (DATA_PAGE_POINTER),
        .phys_addr   (data_addr)
    );
    assign code_addr = {CODE_SEGMENT_POINTER, REQ_ADDR};
    assign phys = REQ_FETCH ? code_addr : data_addr;

    // Hardwired window decode, no software view                     
    assign in_extension_ram = extension_ram_on_ff && (phys >= `EXTENSION_RAM_BASE) &&
                     (phys <= `EXTENSION_RAM_LAST);
    assign in_iram = (phys >= `IRAM_BASE) && (phys <= `IRAM_LAST);
    // ROM sits under the RAM and register areas of segment 0
    assign in_rom  = ROM_ENABLE && (phys <= `ROM_LAST) && !in_iram &&
                     !((phys >= `EXTENSION_RAM_BASE) && (phys <= `EXTENSION_RAM_LAST));

    // Forbidden forms for extension RAM and external memory
    assign bad_mode = (!in_rom && !in_iram) &&
                      (REQ_SHORT || REQ_BIT || REQ_STACK ||
                       (!REQ_BYTE && phys[0]));

    rom_guard #(.PROTECT(ROM_PROTECT)) u_guard (
        .clk          (REF_CLK),
        .rst          (RESET),
        .fetch_done   (DONE),
        .is_fetch     (fetch_ff),
        .rom_hit      (rom_hit_ff),
        .rom_data     (ROM_RDATA),
        .guarded_data (guarded),
        .in_rom       (running_rom)
    );

    // ------------------------------------------------------------
    // Extension RAM enable, off until software turns it on
    // ------------------------------------------------------------
    always @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            extension_ram_on_ff <= 1'b0;
        end else begin
            extension_ram_on_ff <= EXTENSION_RAM_ENABLE_BIT;
        end
    end

    // ------------------------------------------------------------
    // Reset straps and segment pointer
    // ------------------------------------------------------------
    always @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            strap_done_ff        <= 1'b0;
            BUS_MODE             <= `BUS_MUX16;
            SEG_LINES_MASK       <= 6'h00;
            START_EXTERNAL       <= 1'b0;
            CODE_SEGMENT_POINTER <= 8'h00;
        end else begin
            // Straps are caught once, at the first edge after reset
            if (!strap_done_ff) begin
                strap_done_ff  <= 1'b1;
                START_EXTERNAL <= !EXTERNAL_ACCESS_PIN_N;
                BUS_MODE       <= STRAP_BUS_MODE;
                if (STRAP_SEG_MODE == `SEG_2BIT) begin
                    SEG_LINES_MASK <= 6'h03;
                end else if (STRAP_SEG_MODE == `SEG_4BIT) begin
                    SEG_LINES_MASK <= 6'h0F;
                end else if (STRAP_SEG_MODE == `SEG_6BIT) begin
                    SEG_LINES_MASK <= 6'h3F;
                end else begin
                    SEG_LINES_MASK <= 6'h00;
                end
            end
            if (SEG_BRANCH) begin
                CODE_SEGMENT_POINTER <= SEG_TARGET;
            end
        end
    end

    // ------------------------------------------------------------
    // Extension RAM storage, one entry per word
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `EXTENSION_RAM_WORDS; gi = gi + 1) begin : g_extension_ram
            always @(posedge REF_CLK) begin
                if (wen_ff && widx_ff == gi) begin
                    if (!wbyte_ff || !wsel_ff) begin
                        extension_ram_ff[gi][7:0] <= wdata_ff[7:0];
                    end
                    if (!wbyte_ff || wsel_ff) begin
                        extension_ram_ff[gi][15:8] <= wdata_ff[15:8];
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------
    always @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            state_ff   <= ST_IDLE;
            phase_ff   <= 3'h0;
            DONE       <= 1'b0;
            FAULT      <= 1'b0;
            RDATA      <= 16'h0000;
            ROM_RD     <= 1'b0;
            ROM_ADDR   <= 24'h000000;
            EXT_REQ    <= 1'b0;
            EXT_WRITE  <= 1'b0;
            EXT_ADDR   <= 24'h000000;
            EXT_WDATA  <= 16'h0000;
            widx_ff    <= 10'h000;
            wbyte_ff   <= 1'b0;
            wsel_ff    <= 1'b0;
            wen_ff     <= 1'b0;
            wdata_ff   <= 16'h0000;
            fetch_ff   <= 1'b0;
            rom_hit_ff <= 1'b0;
        end else begin
            DONE   <= 1'b0;
            FAULT  <= 1'b0;
            wen_ff <= 1'b0;
            case (state_ff)
            ST_IDLE: begin
                // A request still up while DONE stands is the one just
                // answered, so it is not taken a second time
                if (REQ && strap_done_ff && !DONE) begin
                    // Keep the word index, lane and data for the store
                    fetch_ff   <= REQ_FETCH;
                    rom_hit_ff <= in_rom;
                    widx_ff    <= phys[10:1];
                    wsel_ff    <= phys[0];
                    wbyte_ff   <= REQ_BYTE;
                    wdata_ff   <= REQ_WDATA;
                    if (bad_mode) begin
                        DONE  <= 1'b1;
                        FAULT <= 1'b1;
                    end else if (in_extension_ram) begin
                        phase_ff <= 3'h0;
                        state_ff <= ST_EXTENSION_RAM;
                    end else if (in_rom) begin
                        ROM_RD   <= 1'b1;
                        ROM_ADDR <= phys;
                        state_ff <= ST_ROM;
                    end else begin
                        EXT_REQ   <= 1'b1;
                        EXT_WRITE <= REQ_WRITE;
                        EXT_ADDR  <= phys;
                        EXT_WDATA <= REQ_WDATA;
                        state_ff  <= ST_EXT;
                    end
                    if (in_extension_ram && REQ_WRITE && !bad_mode) begin
                        wen_ff <= 1'b1;
                    end
                end
            end
            ST_EXTENSION_RAM: begin
                // Fixed profile: 4 phases = 2 clocks, no waits
                phase_ff <= phase_ff + 3'h1;
                if (phase_ff == EXTENSION_RAM_END_PH) begin
                    RDATA    <= extension_ram_ff[widx_ff];
                    DONE     <= 1'b1;
                    state_ff <= ST_IDLE;
                end
            end
            ST_ROM: begin
                // ROM data is valid one cycle after its address
                ROM_RD   <= 1'b0;
                RDATA    <= (fetch_ff || !running_rom) ? guarded : ROM_RDATA;
                DONE     <= 1'b1;
                state_ff <= ST_IDLE;
            end
            default: begin
                // External access ends on the far side's answer
                if (EXT_DONE) begin
                    EXT_REQ  <= 1'b0;
                    RDATA    <= EXT_RDATA;
                    DONE     <= 1'b1;
                    state_ff <= ST_IDLE;
                end
            end
            endcase
        end
    end
endmodule

// ==== verilog/mem_decode_map.vh ====
// Purpose: Constants for the memory area decoder and ROM guard
// Assumes: 24-bit physical byte addresses, 16-bit data words
// Notes:   EXTENSION_RAM_CYCLE_CLK counts reference clock cycles, EXTENSION_RAM_CYCLE_PH counts clock phases
`ifndef MEM_DECODE_MAP_VH
`define MEM_DECODE_MAP_VH

// ----------------------------------------------------------------
// Extension RAM window
// ----------------------------------------------------------------
`define EXTENSION_RAM_BASE        24'h00E000
`define EXTENSION_RAM_LAST        24'h00E7FF
`define EXTENSION_RAM_LAST_WORD   24'h00E7FE
`define EXTENSION_RAM_WORDS       1024
`define EXTENSION_RAM_AW          10
`define EXTENSION_RAM_CYCLE_PH    4
`define EXTENSION_RAM_CYCLE_CLK   3'h2

// ----------------------------------------------------------------
// Internal ROM, RAM/SFR areas
// ----------------------------------------------------------------
`define ROM_LAST         24'h00FFFF
`define IRAM_BASE        24'h00F000
`define IRAM_LAST        24'h00FFFF
`define ROM_GUARD_WORD   16'h009B
`define RESET_VECTOR     24'h000000

// ----------------------------------------------------------------
// Bus mode codes and segment widths
// ----------------------------------------------------------------
`define BUS_MUX16        2'h0
`define BUS_MUX8         2'h1
`define BUS_DMX16        2'h2
`define BUS_DMX8         2'h3
`define SEG_NONE         2'h0
`define SEG_2BIT         2'h1
`define SEG_4BIT         2'h2
`define SEG_6BIT         2'h3

`endif

// ==== verilog/page_translate.v ====
// Purpose: Forms a 24-bit physical address from a 16-bit data address
// Assumes: Four data page pointers of 10 bits each
// Notes:   Transfer-engine pointers and long accesses bypass the pointers
`timescale 1ns/1ps
module page_translate (
    // Logical request
    input  wire [15:0] addr16,
    input  wire        direct_seg0,
    input  wire        long_en,
    input  wire [7:0]  long_seg,
    // Page pointers
    input  wire [39:0] page_ptrs,
    // Result
    output reg  [23:0] phys_addr
);
    reg [9:0] page_sel;

    // Top two bits pick the page pointer; page replaces those two bits
    always @* begin
        page_sel = page_ptrs[addr16[15:14]*10 +: 10];
        if (direct_seg0) begin
            phys_addr = {8'h00, addr16};
        end else if (long_en) begin
            phys_addr = {long_seg, addr16};
        end else begin
            phys_addr = {page_sel, addr16[13:0]};
        end
    end
endmodule

// ==== verilog/rom_guard.v ====
// Purpose: Tracks fetch origin and substitutes the guard word
// Assumes: Protection option is a fixed parameter set at build
// Notes:   The guard word decodes as a trap to the reset vector
`timescale 1ns/1ps
`include "mem_decode_map.vh"
module rom_guard #(
    parameter PROTECT = 1'b0
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        fetch_done,
    input  wire        is_fetch,
    input  wire        rom_hit,
    input  wire [15:0] rom_data,
    output wire [15:0] guarded_data,
    output wire        in_rom
);
    reg in_rom_ff;

    // Remember whether the running instruction came from internal ROM
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            in_rom_ff <= 1'b1;
        end else if (fetch_done && is_fetch) begin
            in_rom_ff <= rom_hit;
        end
    end

    // Data reads and fetches from outside see the guard word
    assign guarded_data = (PROTECT && rom_hit && !in_rom_ff) ?
                          `ROM_GUARD_WORD : rom_data;
    assign in_rom = in_rom_ff;
endmodule
